// *** include/uart_fcr_lcr_consts.svh ***
// Purpose: Offsets, fields, codes and reset values
// Assumes: 32-bit byte addresses on the register port
// Notes:   Definitions only
`ifndef UART_FCR_LCR_CONSTS_SVH
`define UART_FCR_LCR_CONSTS_SVH
// Register byte addresses
`define OFS_IDENT_FIFO   32'h5000_1008
`define OFS_LINE_FORMAT  32'h5000_100c
// FIFO control write fields
`define FC_EN            0
`define FC_RX_CLR        1
`define FC_TX_CLR        2
`define FC_DMA           3
`define FC_TX_TRIG       5:4
`define FC_RX_TRIG       7:6
// Line format fields
`define LF_LEN           1:0
`define LF_STOP          2
`define LF_PAR_EN        3
`define LF_EVEN          4
`define LF_BREAK         6
`define LF_DLA           7
// Pending interrupt codes
`define PEND_MODEM       4'h0
`define PEND_NONE        4'h1
`define PEND_TX_EMPTY    4'h2
`define PEND_RX_DATA     4'h4
`define PEND_LINE        4'h6
`define PEND_BUSY        4'h7
`define PEND_TIMEOUT     4'hc
// FIFOs enabled status
`define FIFOS_ON         2'h3
`define FIFOS_OFF        2'h0
// Reset values
`define RST_FIFO_CTRL    8'h00
`define RST_LINE_FORMAT  8'h00
`define RST_RDATA        32'h0000_0000
`endif

// *** include/uart_fcr_lcr_pkg.sv ***
// Purpose: State type of the FIFO and line control block
// Assumes: Nothing
// Notes:   Constants live in the consts header
package uart_fcr_lcr_pkg;
  // All flops of the block
  typedef struct packed {
    logic        fifo_en;
    logic [1:0]  rx_trig;
    logic [1:0]  tx_trig;
    logic        dma_mode;
    logic        dl_access;
    logic        brk;
    logic        even_par;
    logic        par_en;
    logic        two_stop;
    logic [1:0]  data_len;
    logic [31:0] rdata;
    logic        tx_clr;
    logic        rx_clr;
    logic        tx_empty_ack;
    logic        rts_n;
    logic        dma_tx_n;
    logic        dma_rx_n;
    logic        sout;
    logic        sir_out_n;
    logic        rx_loop;
  } fcr_lcr_state_t;
endpackage

// *** src/uart_fcr_lcr.sv ***
// Purpose: FIFO control, interrupt ident and line format
// Assumes: Sibling blocks own FIFOs, divisor, IER, MODEM_CONTROL_REG
// Notes:   Register read data one cycle after strobe
//
// The address-and-strobe port is this design's own decision.
`include "uart_fcr_lcr_consts.svh"
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE1 - One address: read ident, write FIFO control
// RULE2 - FIFOs status reads 00 off, 11 on
// RULE3 - Codes: modem 0000, tx 0010, rx 0100
// RULE4 - None 0001, line 0110, busy 0111, timeout 1100
// RULE5 - Rx trigger: 1, quarter, half, two below full
// RULE6 - Auto flow drops request-to-send at or above rx trigger
// RULE7 - Rx DMA request uses rx trigger
// RULE8 - Tx empty trigger: empty, 2, quarter, half
// RULE9 - Tx DMA request uses tx empty trigger
// RULE10 - DMA mode bit selects mode 0/1
// RULE11 - Tx FIFO reset bit pulses, self-clears
// RULE12 - Rx FIFO reset bit pulses, self-clears
// RULE13 - Bit zero enables both FIFOs
// RULE14 - Divisor access bit redirects shared addresses
// RULE15 - Software clears divisor access after setup
// RULE16 - Break holds serial output low
// RULE17 - Break in infrared mode pulses output
// RULE18 - Loopback break feeds receiver, infrared low
// RULE19 - Parity select one even, zero odd
// RULE20 - Parity enable turns generation and check on
// RULE21 - Stop bits: 1, or 1.5/2 by length
// RULE22 - Receiver checks only first stop bit
// RULE23 - Length field: 5, 6, 7, 8 bits
// RULE24 - Rx enable also gates timeout in FIFO mode
module uart_fcr_lcr #(
  parameter int FIFO_DEPTH = 16,
  parameter int CNT_W      = $clog2(FIFO_DEPTH) + 1
) (
  // Clock, reset, enable
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset,
  input  wire logic             i_clk_en,
  // Register port
  input  wire logic [31:0]      i_addr,
  input  wire logic [31:0]      i_wdata,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  output logic      [31:0]      o_rdata,
  // FIFO fill levels
  input  wire logic [CNT_W-1:0] i_rx_count,
  input  wire logic [CNT_W-1:0] i_tx_count,
  // Interrupt sources
  input  wire logic             i_line_event,
  input  wire logic             i_rx_data_ready,
  input  wire logic             i_char_timeout,
  input  wire logic             i_tx_holding_empty,
  input  wire logic             i_modem_event,
  input  wire logic             i_busy_detect,
  // Interrupt enables
  input  wire logic             i_line_intr_enable,
  input  wire logic             i_rx_data_intr_enable,
  input  wire logic             i_tx_empty_intr_enable,
  input  wire logic             i_modem_intr_enable,
  input  wire logic             i_prog_tx_empty_mode,
  // Modem control
  input  wire logic             i_loopback,
  input  wire logic             i_sir_enable,
  input  wire logic             i_auto_flow_enable,
  input  wire logic             i_rts_request,
  // Serial sources
  input  wire logic             i_tx_serial,
  input  wire logic             i_sir_tx_n,
  input  wire logic             i_sir_pulse_n,
  // Serial pins and loop
  output logic                  o_sout,
  output logic                  o_sir_out_n,
  output logic                  o_rx_loop_data,
  output logic                  o_rts_n,
  // DMA requests
  output logic                  o_dma_tx_req_n,
  output logic                  o_dma_rx_req_n,
  // FIFO control
  output logic                  o_fifo_enable,
  output logic                  o_tx_fifo_clear,
  output logic                  o_rx_fifo_clear,
  output logic                  o_tx_empty_ack,
  // Character format
  output logic                  o_divisor_latch_access,
  output logic      [1:0]       o_data_length_select,
  output logic                  o_two_stop,
  output logic                  o_parity_enable,
  output logic                  o_even_parity_select,
  output logic                  o_break_control,
  output logic                  o_intr_pending
);

  // ************************************************
  // Trigger levels
  // ************************************************

  localparam logic [CNT_W-1:0] LVL_ONE     = CNT_W'(1);
  localparam logic [CNT_W-1:0] LVL_TWO     = CNT_W'(2);
  localparam logic [CNT_W-1:0] LVL_QUARTER = CNT_W'(FIFO_DEPTH / 4);
  localparam logic [CNT_W-1:0] LVL_HALF    = CNT_W'(FIFO_DEPTH / 2);
  localparam logic [CNT_W-1:0] LVL_NEAR    = CNT_W'(FIFO_DEPTH - 2);
  localparam logic [CNT_W-1:0] LVL_EMPTY   = CNT_W'(0);

  uart_fcr_lcr_pkg::fcr_lcr_state_t st;
  uart_fcr_lcr_pkg::fcr_lcr_state_t next_st;

  logic [CNT_W-1:0] rx_level;
  logic [CNT_W-1:0] tx_level;
  logic             rx_hit;
  logic             tx_low;
  logic             rx_avail;
  logic             rx_src;
  logic             tmo_src;
  logic             tx_src;
  logic             line_src;
  logic             modem_src;
  logic [3:0]       pend_code;
  logic [31:0]      ident_word;
  logic [31:0]      format_word;
  logic             hit_fifo;
  logic             hit_format;
  logic             afc_active;

  // RULE5 rx trigger select
  always_comb begin
    case (st.rx_trig)
      2'h0:    rx_level = LVL_ONE;
      2'h1:    rx_level = LVL_QUARTER;
      2'h2:    rx_level = LVL_HALF;
      default: rx_level = LVL_NEAR;
    endcase
  end

  // RULE8 tx empty trigger select
  always_comb begin
    case (st.tx_trig)
      2'h0:    tx_level = LVL_EMPTY;
      2'h1:    tx_level = LVL_TWO;
      2'h2:    tx_level = LVL_QUARTER;
      default: tx_level = LVL_HALF;
    endcase
  end

  // Fill comparisons
  assign rx_hit = (i_rx_count >= rx_level);
  assign tx_low = (i_tx_count <= tx_level);

  // ************************************************
  // Interrupt identification
  // ************************************************

  // Without FIFOs a single held character counts
  assign rx_avail = st.fifo_en ? rx_hit : i_rx_data_ready;

  // Gated interrupt sources
  assign line_src  = i_line_event & i_line_intr_enable;
  // RULE24 rx enable gates timeout
  assign rx_src    = rx_avail & i_rx_data_intr_enable;
  assign tmo_src   = i_char_timeout & st.fifo_en
                   & i_rx_data_intr_enable;
  assign modem_src = i_modem_event & i_modem_intr_enable;

  // RULE8 threshold only in programmable mode
  always_comb begin
    if (i_prog_tx_empty_mode && st.fifo_en) begin
      tx_src = tx_low & i_tx_empty_intr_enable;
    end else begin
      tx_src = i_tx_holding_empty & i_tx_empty_intr_enable;
    end
  end

  // RULE3 highest priority wins
  // RULE4 remaining codes
  always_comb begin
    if (line_src) begin
      pend_code = `PEND_LINE;
    end else if (rx_src) begin
      pend_code = `PEND_RX_DATA;
    end else if (tmo_src) begin
      pend_code = `PEND_TIMEOUT;
    end else if (tx_src) begin
      pend_code = `PEND_TX_EMPTY;
    end else if (modem_src) begin
      pend_code = `PEND_MODEM;
    end else if (i_busy_detect) begin
      pend_code = `PEND_BUSY;
    end else begin
      pend_code = `PEND_NONE;
    end
  end

  // RULE2 status field from enable
  always_comb begin
    ident_word      = 32'h0000_0000;
    ident_word[3:0] = pend_code;
    ident_word[7:6] = st.fifo_en ? `FIFOS_ON : `FIFOS_OFF;
  end

  // Reserved bit 5 and upper bits read as zero
  always_comb begin
    format_word                = 32'h0000_0000;
    format_word[`LF_LEN]       = st.data_len;
    format_word[`LF_STOP]      = st.two_stop;
    format_word[`LF_PAR_EN]    = st.par_en;
    format_word[`LF_EVEN]      = st.even_par;
    format_word[`LF_BREAK]     = st.brk;
    format_word[`LF_DLA]       = st.dl_access;
  end

  // ************************************************
  // Address decode
  // ************************************************

  // RULE1 shared read and write address
  assign hit_fifo   = (i_addr == `OFS_IDENT_FIFO);
  assign hit_format = (i_addr == `OFS_LINE_FORMAT);

  // RULE6 flow gate needs FIFOs on
  assign afc_active = i_auto_flow_enable & st.fifo_en;

  // ************************************************
  // Next state
  // ************************************************

  always_comb begin
    next_st = st;
    // Pulses last one cycle
    next_st.tx_clr       = 1'b0;
    next_st.rx_clr       = 1'b0;
    next_st.tx_empty_ack = 1'b0;

    // RULE1 write side is FIFO control
    if (i_wr && hit_fifo) begin
      // RULE13 one bit for both FIFOs
      next_st.fifo_en  = i_wdata[`FC_EN];
      next_st.rx_trig  = i_wdata[`FC_RX_TRIG];
      next_st.tx_trig  = i_wdata[`FC_TX_TRIG];
      // RULE10 DMA mode store
      next_st.dma_mode = i_wdata[`FC_DMA];
      // RULE11 tx clear pulse, never stored
      // Toggling the enable also flushes stale data
      next_st.tx_clr   = i_wdata[`FC_TX_CLR]
                       | (i_wdata[`FC_EN] ^ st.fifo_en);
      // RULE12 rx clear pulse, never stored
      next_st.rx_clr   = i_wdata[`FC_RX_CLR]
                       | (i_wdata[`FC_EN] ^ st.fifo_en);
    end else if (i_wr && hit_format) begin
      // RULE14 divisor access flag
      // RULE15 software clears it afterwards
      next_st.dl_access = i_wdata[`LF_DLA];
      // RULE16 break flag
      next_st.brk       = i_wdata[`LF_BREAK];
      // RULE19 even or odd select
      next_st.even_par  = i_wdata[`LF_EVEN];
      // RULE20 parity on or off
      next_st.par_en    = i_wdata[`LF_PAR_EN];
      // RULE21 stop bit count
      next_st.two_stop  = i_wdata[`LF_STOP];
      // RULE23 character length
      next_st.data_len  = i_wdata[`LF_LEN];
    end

    // Read data valid only the cycle after
    next_st.rdata = `RST_RDATA;
    if (i_rd) begin
      if (hit_fifo) begin
        // RULE1 read side is identification
        next_st.rdata = ident_word;
        // Reading the ident retires a tx-empty cause
        next_st.tx_empty_ack = (pend_code == `PEND_TX_EMPTY);
      end else if (hit_format) begin
        next_st.rdata = format_word;
      end else begin
        next_st.rdata = `RST_RDATA;
      end
    end

    // RULE6 flow gate on request-to-send
    // Loopback parks the pin inactive
    if (i_loopback) begin
      next_st.rts_n = 1'b1;
    end else begin
      next_st.rts_n = ~(i_rts_request & ~(afc_active & rx_hit));
    end

    // RULE7 rx request from rx trigger
    // RULE10 mode 0 one char, mode 1 trigger
    if (!st.fifo_en) begin
      next_st.dma_rx_n = ~i_rx_data_ready;
    end else if (st.dma_mode) begin
      next_st.dma_rx_n = ~(rx_hit | i_char_timeout);
    end else begin
      next_st.dma_rx_n = ~(i_rx_count != LVL_EMPTY);
    end

    // RULE9 tx request from tx trigger
    // RULE10 mode 0 empty, mode 1 threshold
    if (!st.fifo_en) begin
      next_st.dma_tx_n = ~i_tx_holding_empty;
    end else if (st.dma_mode) begin
      next_st.dma_tx_n = ~tx_low;
    end else begin
      next_st.dma_tx_n = ~(i_tx_count == LVL_EMPTY);
    end

    // RULE16 break forces spacing
    // Loopback keeps the line marking
    if (i_loopback) begin
      next_st.sout = 1'b1;
    end else if (st.brk) begin
      next_st.sout = 1'b0;
    end else begin
      next_st.sout = i_tx_serial;
    end

    // RULE18 loopback infrared held low
    // RULE17 break pulses infrared
    if (i_loopback) begin
      next_st.sir_out_n = 1'b0;
    end else if (st.brk && i_sir_enable) begin
      next_st.sir_out_n = i_sir_pulse_n;
    end else begin
      next_st.sir_out_n = i_sir_tx_n;
    end

    // RULE18 break looped to receiver
    if (st.brk) begin
      next_st.rx_loop = 1'b0;
    end else begin
      next_st.rx_loop = i_tx_serial;
    end
  end

  // ************************************************
  // State register
  // ************************************************

  // Clock enable low freezes everything
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      st.fifo_en      <= 1'(`RST_FIFO_CTRL >> `FC_EN);
      st.rx_trig      <= 2'h0;
      st.tx_trig      <= 2'h0;
      st.dma_mode     <= 1'b0;
      st.dl_access    <= 1'b0;
      st.brk          <= 1'b0;
      st.even_par     <= 1'b0;
      st.par_en       <= 1'b0;
      st.two_stop     <= 1'b0;
      st.data_len     <= 2'h0;
      st.rdata        <= `RST_RDATA;
      st.tx_clr       <= 1'b0;
      st.rx_clr       <= 1'b0;
      st.tx_empty_ack <= 1'b0;
      st.rts_n        <= 1'b1;
      st.dma_tx_n     <= 1'b1;
      st.dma_rx_n     <= 1'b1;
      st.sout         <= 1'b1;
      st.sir_out_n    <= 1'b0;
      st.rx_loop      <= 1'b1;
    end else if (i_clk_en) begin
      st <= next_st;
    end
  end

  // ************************************************
  // Outputs
  // ************************************************

  // Data outputs straight from flops
  assign o_rdata                = st.rdata;
  assign o_sout                 = st.sout;
  assign o_sir_out_n            = st.sir_out_n;
  assign o_rx_loop_data         = st.rx_loop;
  assign o_rts_n                = st.rts_n;
  assign o_dma_tx_req_n         = st.dma_tx_n;
  assign o_dma_rx_req_n         = st.dma_rx_n;
  assign o_fifo_enable          = st.fifo_en;
  assign o_tx_fifo_clear        = st.tx_clr;
  assign o_rx_fifo_clear        = st.rx_clr;
  assign o_tx_empty_ack         = st.tx_empty_ack;
  // RULE14 siblings redirect shared addresses
  assign o_divisor_latch_access = st.dl_access;
  // RULE22 receiver checks first stop only
  assign o_two_stop             = st.two_stop;
  assign o_data_length_select   = st.data_len;
  assign o_parity_enable        = st.par_en;
  assign o_even_parity_select   = st.even_par;
  assign o_break_control        = st.brk;
  // Any cause other than none is pending
  assign o_intr_pending         = (pend_code != `PEND_NONE);

endmodule
`default_nettype wire

// *** dv/uart_fcr_lcr_chk.sv ***
// Purpose: Port checks for FIFO and line control
// Assumes: Accesses with enable low are ignored
// Notes:   Bound to every design instance
`include "uart_fcr_lcr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module uart_fcr_lcr_chk (
  // Clock, reset, bus
  input wire logic        i_sys_clk,
  input wire logic        i_reset,
  input wire logic        i_clk_en,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic        i_loopback,
  // Watched outputs
  input wire logic [31:0] o_rdata,
  input wire logic        o_sout,
  input wire logic        o_sir_out_n,
  input wire logic        o_rx_loop_data,
  input wire logic        o_fifo_enable,
  input wire logic        o_tx_fifo_clear,
  input wire logic        o_rx_fifo_clear,
  input wire logic        o_divisor_latch_access,
  input wire logic [1:0]  o_data_length_select,
  input wire logic        o_parity_enable,
  input wire logic        o_even_parity_select,
  input wire logic        o_break_control,
  input wire logic        o_intr_pending
);
  // Accepted accesses only; frozen edges take nothing
  logic wr_fc;
  logic wr_lf;
  logic rd_fc;
  assign wr_fc = i_wr && i_clk_en && (i_addr == `OFS_IDENT_FIFO);
  assign wr_lf = i_wr && i_clk_en && (i_addr == `OFS_LINE_FORMAT);
  assign rd_fc = i_rd && i_clk_en && (i_addr == `OFS_IDENT_FIFO);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // ****************
  // Assertions
  // ****************
  property p_fifo_en; wr_fc |=> o_fifo_enable == $past(i_wdata[0]); endproperty
  a_fifo_en: assert property (p_fifo_en) else $error("fifo enable not taken");
  property p_tx_clr; wr_fc && i_wdata[2] |=> o_tx_fifo_clear; endproperty
  a_tx_clr: assert property (p_tx_clr) else $error("tx clear missing");
  property p_rx_self; o_rx_fifo_clear && i_clk_en && !wr_fc |=> !o_rx_fifo_clear; endproperty
  a_rx_self: assert property (p_rx_self) else $error("rx clear stuck");
  property p_status; rd_fc |=> o_rdata[7:6] == {2{o_fifo_enable}} && o_rdata[31:8] == 24'h0; endproperty
  a_status: assert property (p_status) else $error("fifo status wrong");
  property p_code; rd_fc |=> (o_rdata[3:0] != `PEND_NONE) == $past(o_intr_pending); endproperty
  a_code: assert property (p_code) else $error("code and pending disagree");
  property p_len; wr_lf |=> o_data_length_select == $past(i_wdata[1:0]); endproperty
  a_len: assert property (p_len) else $error("length not taken");
  property p_par; wr_lf |=> {o_even_parity_select, o_parity_enable} == $past(i_wdata[4:3]); endproperty
  a_par: assert property (p_par) else $error("parity not taken");
  property p_dla; wr_fc |=> $stable(o_divisor_latch_access) && $stable(o_data_length_select); endproperty
  a_dla: assert property (p_dla) else $error("ident write hit format");
  property p_brk; o_break_control && !i_loopback && i_clk_en |=> !o_sout; endproperty
  a_brk: assert property (p_brk) else $error("break not spacing");
  property p_loop; o_break_control && i_loopback && i_clk_en |=> o_sout && !o_sir_out_n && !o_rx_loop_data;
  endproperty
  a_loop: assert property (p_loop) else $error("loopback break wrong");
  // Main scenarios reached
  c_clr: cover property (wr_fc && i_wdata[2]);
  c_loop: cover property (o_break_control && i_loopback);
  c_tmo: cover property (rd_fc ##1 o_rdata[3:0] == `PEND_TIMEOUT);
endmodule
bind uart_fcr_lcr uart_fcr_lcr_chk uart_fcr_lcr_chk_inst (.i_sys_clk, .i_reset, .i_clk_en, .i_addr, .i_wdata,
  .i_wr, .i_rd, .i_loopback, .o_rdata, .o_sout, .o_sir_out_n, .o_rx_loop_data, .o_fifo_enable, .o_tx_fifo_clear,
  .o_rx_fifo_clear, .o_divisor_latch_access, .o_data_length_select, .o_parity_enable, .o_even_parity_select,
  .o_break_control, .o_intr_pending);
`default_nettype wire

// *** dv/remote_serial_model.sv ***
// Purpose: Far-end serial device watching the line
// Assumes: Line sampled on the system clock
// Notes:   Only break detection is modelled
`timescale 1ns/1ps
`default_nettype none
module remote_serial_model #(
  parameter int BRK_CYC = 8
) (
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_reset,
  // Serial line
  input  wire logic i_line,
  output logic      o_break_seen
);
  int low_cnt;
  // Long spacing reads as break; short lows are data
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      low_cnt <= 0;
      o_break_seen <= 1'b0;
    end else begin
      low_cnt <= i_line ? 0 : low_cnt + 1;
      o_break_seen <= (low_cnt >= BRK_CYC);
    end
  end
endmodule
`default_nettype wire

// *** dv/uart_fcr_lcr_tb.sv ***
// Purpose: Self-checking bench for FIFO and line control
// Assumes: 50 MHz clock, clock enable mostly high
// Notes:   Seed 19 feeds format data and serial input
`include "uart_fcr_lcr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module uart_fcr_lcr_tb;
  // Design inputs
  logic        i_sys_clk, i_reset, i_clk_en, i_wr, i_rd;
  logic [31:0] i_addr, i_wdata;
  logic [4:0]  i_rx_count, i_tx_count;
  logic [5:0]  src;
  logic [3:0]  ien;
  logic        i_prog_tx_empty_mode, i_loopback, i_sir_enable, i_auto_flow_enable;
  logic        i_rts_request, i_tx_serial, i_sir_tx_n, i_sir_pulse_n;
  // Design outputs
  logic [31:0] o_rdata;
  logic [1:0]  o_data_length_select;
  logic        o_sout, o_sir_out_n, o_rx_loop_data, o_rts_n, o_dma_tx_req_n, o_dma_rx_req_n, o_tx_empty_ack;
  logic        o_fifo_enable, o_tx_fifo_clear, o_rx_fifo_clear, o_divisor_latch_access, o_two_stop;
  logic        o_parity_enable, o_even_parity_select, o_break_control, o_intr_pending, brk_seen;
  // Bench state; table is {enables, sources, code}
  int          fail_count = 0, cmp_count = 0, seed = 19, cyc = 0;
  logic [31:0] rd_data, d;
  localparam logic [13:0] TBL [8] = '{14'h3c01, 14'h3c17, 14'h3c20, 14'h3c62, 14'h3d64, 14'h3ff6, 14'h03f7,
                                      14'h3cec};
  uart_fcr_lcr uart_fcr_lcr_inst (.i_sys_clk, .i_reset, .i_clk_en, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_rx_count, .i_tx_count, .i_line_event(src[5]), .i_rx_data_ready(src[4]), .i_char_timeout(src[3]),
    .i_tx_holding_empty(src[2]), .i_modem_event(src[1]), .i_busy_detect(src[0]), .i_line_intr_enable(ien[3]),
    .i_rx_data_intr_enable(ien[2]), .i_tx_empty_intr_enable(ien[1]), .i_modem_intr_enable(ien[0]),
    .i_prog_tx_empty_mode, .i_loopback, .i_sir_enable, .i_auto_flow_enable, .i_rts_request, .i_tx_serial,
    .i_sir_tx_n, .i_sir_pulse_n, .o_sout, .o_sir_out_n, .o_rx_loop_data, .o_rts_n, .o_dma_tx_req_n,
    .o_dma_rx_req_n, .o_fifo_enable, .o_tx_fifo_clear, .o_rx_fifo_clear, .o_tx_empty_ack,
    .o_divisor_latch_access, .o_data_length_select, .o_two_stop, .o_parity_enable, .o_even_parity_select,
    .o_break_control, .o_intr_pending);
  remote_serial_model remote_serial_model_inst (.i_sys_clk, .i_reset, .i_line(o_sout), .o_break_seen(brk_seen));
  // ****************
  // Helpers
  // ****************
  function automatic int rx_lvl(input int t);
    return (t == 0) ? 1 : (t == 1) ? 4 : (t == 2) ? 8 : 14;
  endfunction
  function automatic int tx_lvl(input int t);
    return (t == 0) ? 0 : (1 << t);
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    rd_data = o_rdata;
  endtask
  // Registered pins need one edge past the driving edge
  task automatic step();
    repeat (2) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Clock and hang guard
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      print_verdict();
    end
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    {i_wr, i_rd, i_addr, i_wdata, i_rx_count, i_tx_count, src, ien} = '0;
    {i_prog_tx_empty_mode, i_loopback, i_sir_enable, i_auto_flow_enable} = '0;
    {i_rts_request, i_tx_serial, i_sir_tx_n, i_sir_pulse_n} = '0;
    i_clk_en = 1'b1;
    i_reset = 1'b1;
    repeat (16) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    #1;
    chk("reset rdata", 32'h0, o_rdata);
    chk("reset cfg", 32'h0, {o_fifo_enable, o_divisor_latch_access, o_break_control, o_two_stop, o_parity_enable,
                             o_even_parity_select, o_data_length_select, o_tx_fifo_clear, o_rx_fifo_clear,
                             o_tx_empty_ack});
    chk("reset pins", 32'h3d, {o_sout, o_rts_n, o_dma_rx_req_n, o_dma_tx_req_n, o_sir_out_n, o_rx_loop_data});
    // Format fields, corners then random; last clears divisor access
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 32'hff : (i == 7) ? 32'h03 : $random(seed);
      wr(`OFS_LINE_FORMAT, d);
      chk("len", d[1:0], o_data_length_select);
      chk("parity", d[4:3], {o_even_parity_select, o_parity_enable});
      chk("stop", d[2], o_two_stop);
      chk("dla", d[7], o_divisor_latch_access);
      rd(`OFS_LINE_FORMAT);
      chk("fmt read", {24'h0, d[7:0] & 8'hdf}, rd_data);
    end
    wr(32'h5000_1004, 32'hff);
    rd(`OFS_LINE_FORMAT);
    chk("unmapped wr", 32'h03, rd_data);
    rd(32'h5000_1004);
    chk("unmapped rd", 32'h0, rd_data);
    // Enable low: a write must not land
    @(posedge i_sys_clk);
    i_clk_en <= 1'b0;
    wr(`OFS_LINE_FORMAT, 32'h00);
    chk("frozen", 2'h3, o_data_length_select);
    @(posedge i_sys_clk);
    i_clk_en <= 1'b1;
    // Every pending code and priority; last row needs FIFOs on
    for (int i = 0; i < 8; i++) begin
      if (i == 7) wr(`OFS_IDENT_FIFO, 32'h01);
      @(posedge i_sys_clk);
      {ien, src} <= TBL[i][13:4];
      step();
      rd(`OFS_IDENT_FIFO);
      chk("code", TBL[i][3:0], rd_data[3:0]);
      chk("fifo status", (i == 7) ? 2'h3 : 2'h0, rd_data[7:6]);
    end
    // Trigger levels: rx one below and at, tx one above and at each level, mode 1
    @(posedge i_sys_clk);
    {i_auto_flow_enable, i_rts_request, i_prog_tx_empty_mode} <= 3'h7;
    {ien, src} <= 10'h080;
    for (int t = 0; t < 4; t++) begin
      wr(`OFS_IDENT_FIFO, {t[1:0], t[1:0], 4'h9});
      for (int k = 0; k < 2; k++) begin
        @(posedge i_sys_clk);
        i_rx_count <= 5'(rx_lvl(t) - 1 + k);
        i_tx_count <= 5'(tx_lvl(t) + 1 - k);
        step();
        chk("rts", k, o_rts_n);
        chk("dma rx", 1 - k, o_dma_rx_req_n);
        chk("dma tx", 1 - k, o_dma_tx_req_n);
        rd(`OFS_IDENT_FIFO);
        chk("tx code", k ? 4'h2 : 4'h1, rd_data[3:0]);
        chk("tx ack", k, o_tx_empty_ack);
        chk("pending", k, o_intr_pending);
      end
    end
    // Mode 0 requests follow plain fill
    wr(`OFS_IDENT_FIFO, 32'h01);
    for (int k = 0; k < 2; k++) begin
      @(posedge i_sys_clk);
      i_rx_count <= 5'(k);
      i_tx_count <= 5'(1 - k);
      step();
      chk("dma0", {2{k[0] ? 1'b0 : 1'b1}}, {o_dma_rx_req_n, o_dma_tx_req_n});
    end
    // Self-clearing FIFO resets, then FIFOs off
    wr(`OFS_IDENT_FIFO, 32'h05);
    chk("tx clr", 2'h2, {o_tx_fifo_clear, o_rx_fifo_clear});
    @(posedge i_sys_clk);
    #1;
    chk("clr off", 2'h0, {o_tx_fifo_clear, o_rx_fifo_clear});
    wr(`OFS_IDENT_FIFO, 32'h03);
    chk("rx clr", 2'h1, {o_tx_fifo_clear, o_rx_fifo_clear});
    wr(`OFS_IDENT_FIFO, 32'h00);
    chk("fifo off", 3'h3, {o_fifo_enable, o_tx_fifo_clear, o_rx_fifo_clear});
    // Break on the line, infrared, then loopback
    @(posedge i_sys_clk);
    {i_auto_flow_enable, i_rts_request, i_prog_tx_empty_mode, i_sir_tx_n} <= 4'h1;
    wr(`OFS_LINE_FORMAT, 32'h43);
    step();
    chk("sout break", 1'b0, o_sout);
    repeat (10) @(posedge i_sys_clk);
    #1;
    chk("far break", 1'b1, brk_seen);
    for (int k = 0; k < 2; k++) begin
      @(posedge i_sys_clk);
      i_sir_enable <= 1'b1;
      i_sir_pulse_n <= k[0];
      step();
      chk("sir pulse", k, o_sir_out_n);
    end
    @(posedge i_sys_clk);
    i_loopback <= 1'b1;
    step();
    chk("loop break", 3'h4, {o_sout, o_sir_out_n, o_rx_loop_data});
    wr(`OFS_LINE_FORMAT, 32'h03);
    for (int k = 0; k < 8; k++) begin
      @(posedge i_sys_clk);
      d = $random(seed);
      i_tx_serial <= d[0];
      step();
      chk("loop data", d[0], o_rx_loop_data);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
